// [bench/tmr8_core_bench.sv]
// self-checking bench for the 8-bit timer/counter block
`timescale 1ns/1ns
module tmr8_core_bench;
    import tmr8_pkg::*;
    logic        mclk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic [4:0]  avs_address_i = 5'h00;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0]  avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        ext_count_pin_i = 1'b0;
    logic        global_irq_en_i = 1'b1;
    logic        wave_out_a_o, wave_out_b_o, wave_oe_a_o, wave_oe_b_o, irq_o;
    int          bad_count = 0;
    int          total_checks = 0;
    logic [31:0] seed = 32'h0000_312C;
    logic [31:0] v;
    int          divs[5] = '{1, DIV_8, DIV_64, DIV_256, DIV_1024};
    int          e;
    logic [7:0]  r;
    logic        wait_s = 1'b1;
    logic [31:0] rd_s = 32'h0000_0000;

    // settled copies, so each rising edge sees what stood before it
    always @(negedge mclk_i) begin
        wait_s <= avs_waitrequest_o;
        rd_s   <= avs_readdata_o;
    end

    tmr8_core DUT (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .ext_count_pin_i(ext_count_pin_i),
        .global_irq_en_i(global_irq_en_i), .wave_out_a_o(wave_out_a_o),
        .wave_out_b_o(wave_out_b_o), .wave_oe_a_o(wave_oe_a_o), .wave_oe_b_o(wave_oe_b_o),
        .irq_o(irq_o));

    initial begin
        forever #20 mclk_i = ~mclk_i;
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address_i <= a;
        avs_writedata_i <= {xs() & 32'hFFFF_FF00} | {24'h0, d};
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        @(posedge mclk_i);
        while (wait_s !== 1'b0 && n < 200) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 200) chk("bus answer", 0, 1);
        v = rd_s;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        // one idle edge so a following call never re-raises in this time step
        @(posedge mclk_i);
    endtask

    task automatic rd_chk(input string name, input logic [4:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(name, v, {24'h0, exp});
    endtask

    task automatic run(input logic [7:0] start, input logic [2:0] cs, input int cyc);
        bus(1'b1, ADDR_COUNT, start);
        bus(1'b1, ADDR_CTRL_B, {5'h00, cs});
        repeat (cyc) @(posedge mclk_i);
        bus(1'b1, ADDR_CTRL_B, 8'h00);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge mclk_i);
        bad_count++;
        end_of_test();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        @(posedge mclk_i);
        rd_chk("ctrl_b reset", ADDR_CTRL_B, 8'h00);
        rd_chk("mask reset", ADDR_MASK, 8'h00);
        r = xs();
        bus(1'b1, ADDR_CTRL_A, r);
        rd_chk("ctrl_a reserved", ADDR_CTRL_A, r & 8'hF3);
        bus(1'b1, ADDR_CTRL_A, 8'h00);
        bus(1'b1, ADDR_MASK, r | 8'hF8);
        rd_chk("mask reserved", ADDR_MASK, 8'h00 | (r & 8'h07));
        bus(1'b1, ADDR_CTRL_B, 8'h30);
        rd_chk("ctrl_b reserved", ADDR_CTRL_B, 8'h00);
        foreach (divs[i]) begin
            r = xs();
            bus(1'b1, ADDR_COUNT + 5'(i % 3) * 5'h04 + ((i % 3 == 0) ? 5'h00 : 5'h00), r);
            rd_chk("reg readback", ADDR_COUNT + 5'(i % 3) * 5'h04, r);
        end
        rd_chk("unmapped", 5'h02, 8'h00);
        bus(1'b1, ADDR_FLAGS, 8'h07);
        bus(1'b1, ADDR_COUNT, 8'h00);
        $display("registers done");
        // forced compares, stopped clock, normal then pwm then ctc
        bus(1'b1, ADDR_CTRL_A, 8'h70);
        chk("oe both", {wave_oe_a_o, wave_oe_b_o}, 2'b11);
        bus(1'b1, ADDR_CTRL_B, 8'h80);
        chk("force a toggle", wave_out_a_o, 1'b1);
        bus(1'b1, ADDR_CTRL_B, 8'hC0);
        chk("force both", {wave_out_a_o, wave_out_b_o}, 2'b01);
        rd_chk("force no flag", ADDR_FLAGS, 8'h00);
        rd_chk("force no clear", ADDR_COUNT, 8'h00);
        rd_chk("force reads zero", ADDR_CTRL_B, 8'h00);
        bus(1'b1, ADDR_CTRL_A, 8'hC3);
        bus(1'b1, ADDR_CTRL_B, 8'h80);
        chk("force in pwm", wave_out_a_o, 1'b0);
        bus(1'b1, ADDR_CTRL_B, 8'h00);
        bus(1'b1, ADDR_CTRL_A, 8'hC2);
        bus(1'b1, ADDR_COUNT, 8'h05);
        bus(1'b1, ADDR_CTRL_B, 8'h80);
        chk("force in ctc", wave_out_a_o, 1'b1);
        rd_chk("ctc no clear", ADDR_COUNT, 8'h05);
        $display("force done");
        // clear-on-compare wraps at compare a, no overflow
        bus(1'b1, ADDR_CTRL_A, 8'h02);
        bus(1'b1, ADDR_CMP_A, 8'h10);
        bus(1'b1, ADDR_CMP_B, 8'h80);
        run(8'h00, CS_DIV1, 100);
        bus(1'b0, ADDR_COUNT, 8'h00);
        chk("ctc top", v <= 32'h10, 1'b1);
        rd_chk("ctc flags", ADDR_FLAGS, 8'h02);
        bus(1'b1, ADDR_FLAGS, 8'h07);
        bus(1'b1, ADDR_CTRL_A, 8'h00);
        // a counter write blocks the next match
        bus(1'b1, ADDR_CMP_A, 8'h20);
        run(8'h20, CS_DIV1, 10);
        rd_chk("write blocks match", ADDR_FLAGS, 8'h00);
        $display("ctc and block done");
        // flags, mask, global enable, clearing
        bus(1'b1, ADDR_MASK, 8'h07);
        bus(1'b1, ADDR_CMP_A, 8'h40);
        bus(1'b1, ADDR_CMP_B, 8'hC0);
        run(8'h30, CS_DIV1, 40);
        rd_chk("cmp a flag", ADDR_FLAGS, 8'h02);
        chk("irq raised", irq_o, 1'b1);
        global_irq_en_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        chk("irq global off", irq_o, 1'b0);
        global_irq_en_i <= 1'b1;
        bus(1'b1, ADDR_FLAGS, 8'h05);
        rd_chk("zero keeps flag", ADDR_FLAGS, 8'h02);
        bus(1'b1, ADDR_VECACK, 8'h02);
        rd_chk("vector clears", ADDR_FLAGS, 8'h00);
        chk("irq dropped", irq_o, 1'b0);
        run(8'hF0, CS_DIV1, 40);
        rd_chk("overflow flag", ADDR_FLAGS, 8'h01);
        chk("ovf irq", irq_o, 1'b1);
        bus(1'b1, ADDR_MASK, 8'h06);
        repeat (2) @(posedge mclk_i);
        chk("ovf masked", irq_o, 1'b0);
        bus(1'b1, ADDR_FLAGS, 8'h01);
        rd_chk("one clears", ADDR_FLAGS, 8'h00);
        $display("flags done");
        // prescaler taps and stop
        foreach (divs[i]) begin
            r = xs() & 8'h3F;
            run(r, CS_DIV1 + 3'(i), 16 * divs[i]);
            bus(1'b0, ADDR_COUNT, 8'h00);
            e = r + (16 * divs[i] + 2) / divs[i];
            chk("prescale", (int'(v) >= e - 2) && (int'(v) <= e + 2), 1'b1);
        end
        run(8'h33, CS_STOP, 50);
        rd_chk("stopped", ADDR_COUNT, 8'h33);
        $display("prescaler done");
        // external pin, driven as an output meanwhile
        bus(1'b1, ADDR_CTRL_A, 8'h40);
        chk("pin driven", wave_oe_a_o, 1'b1);
        for (int m = 0; m < 2; m++) begin
            bus(1'b1, ADDR_COUNT, 8'h00);
            bus(1'b1, ADDR_CTRL_B, {5'h00, (m == 0) ? CS_EXT_RISE : CS_EXT_FALL});
            repeat (5) begin
                ext_count_pin_i <= 1'b1;
                repeat (3 + xs() % 4) @(posedge mclk_i);
                ext_count_pin_i <= 1'b0;
                repeat (3 + xs() % 4) @(posedge mclk_i);
            end
            bus(1'b1, ADDR_CTRL_B, 8'h00);
            rd_chk("ext edges", ADDR_COUNT, 8'h05);
        end
        $display("external done");
        end_of_test();
    end
endmodule

// [hdl/tmr8_core.sv]
// 8-bit timer/counter with two compare channels and an Avalon-MM register slave
//
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ns
//
// Summary of operation
// [R1] three wave-select bits pick normal, ctc, fast or phase-correct pwm; 4, 6 reserved
// [R2] compare values load at once in non-pwm modes, at top in pwm modes
// [R3] overflow flag at max, at bottom in phase-correct, at top in fast cmp-a mode
// [R4] unused bits of control, mask and flag registers read zero
// [R5] force-compare bits act only in non-pwm modes
// [R6] software writes zero to force bits while a pwm mode runs
// [R7] a force bit applies an immediate match using the current output mode
// [R8] forced match sets no flag, raises no interrupt, never clears counter
// [R9] force bits read as zero
// [R10] clock select: stop, undivided, then prescaler taps 8, 64, 256, 1024
// [R11] codes 110 and 111 count falling or rising edges of the external pin
// [R12] external pin counts even when driven as an output
// [R13] counter is readable and writable by software
// [R14] counter write blocks compare matches on the next timer tick
// [R15] compare values are compared with the counter continuously
// [R16] mask bits 2,1,0 enable cmp b, cmp a, overflow gated by global bit
// [R17] compare flags set on match, overflow flag on overflow
// [R18] flags clear when the processor takes the matching vector
// [R19] writing one to a flag clears it, zero leaves it
// [R20] non-pwm output code: off, toggle, clear, set on match
// [R21] one clock; the selected timer tick is a one-cycle count enable
module tmr8_core
    import tmr8_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        ext_count_pin_i,
    input  wire logic        global_irq_en_i,
    output logic             wave_out_a_o,
    output logic             wave_out_b_o,
    output logic             wave_oe_a_o,
    output logic             wave_oe_b_o,
    output logic             irq_o
);
    tmr8_state_t st_ff;
    tmr8_state_t nxt_st;

    // ****************************************
    // helper decodes
    // ****************************************
    function automatic logic is_pwm(input logic [2:0] wm);
        is_pwm = (wm != WM_NORMAL) && (wm != WM_CTC);
    endfunction

    function automatic logic is_pc(input logic [2:0] wm);
        is_pc = (wm == WM_PC_FF) || (wm == WM_PC_CMPA);
    endfunction

    function automatic logic apply_out(input logic cur, input logic [1:0] om);
        case (om) // R20
            OM_TOGGLE: apply_out = ~cur;
            OM_CLEAR:  apply_out = 1'b0;
            OM_SET:    apply_out = 1'b1;
            default:   apply_out = cur;
        endcase
    endfunction

    logic [2:0] wmode;
    logic       tick;
    logic [7:0] top;
    logic       wr_hit;
    logic       bus_wr;
    logic       bus_rd;
    logic       at_top;
    logic       match_a;
    logic       match_b;
    logic       ovf_ev;
    logic [7:0] wbyte;

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        nxt_st = st_ff;
        wbyte  = avs_writedata_i[7:0];
        wmode  = {st_ff.ctrl_b[WAVE_HIGH_BIT], st_ff.ctrl_a[1:0]}; // R1
        // a write lands at the answer edge, where the master sees waitrequest low
        bus_wr = avs_write_i && (st_ff.bus_st == BUS_ANSWER) && avs_byteenable_i[0];
        bus_rd = avs_read_i && (st_ff.bus_st == BUS_IDLE);
        // timer tick as count enable, not a clock
        case (st_ff.ctrl_b[2:0]) // R10 R21
            CS_DIV1:     tick = 1'b1;
            CS_DIV8:     tick = (st_ff.presc[2:0] == 3'h7);
            CS_DIV64:    tick = (st_ff.presc[5:0] == 6'h3F);
            CS_DIV256:   tick = (st_ff.presc[7:0] == 8'hFF);
            CS_DIV1K:    tick = (st_ff.presc == 10'h3FF);
            // pin sampled as a plain input, even when the pin is an output
            CS_EXT_FALL: tick = st_ff.ext_d && !ext_count_pin_i; // R11 R12
            CS_EXT_RISE: tick = !st_ff.ext_d && ext_count_pin_i; // R11 R12
            default:     tick = 1'b0;
        endcase
        nxt_st.presc = st_ff.presc + 10'h001;
        nxt_st.ext_d = ext_count_pin_i;
        top = ((wmode == WM_CTC) || (wmode == WM_PC_CMPA) || (wmode == WM_FAST_CMPA))
            ? st_ff.cmp_a_act : VAL_MAX;
        at_top  = (st_ff.count == top);
        // R15: continuous compare, suppressed one tick after a counter write
        match_a = tick && !st_ff.block_match && (st_ff.count == st_ff.cmp_a_act); // R14 R15
        match_b = tick && !st_ff.block_match && (st_ff.count == st_ff.cmp_b_act); // R14 R15
        ovf_ev  = 1'b0;
        wr_hit  = bus_wr && (avs_address_i == ADDR_COUNT);
        if (tick) begin
            nxt_st.block_match = 1'b0;
            if (is_pc(wmode)) begin
                if (!st_ff.down) begin
                    if (at_top) begin
                        nxt_st.down  = 1'b1;
                        nxt_st.count = st_ff.count - 8'h01;
                    end else begin
                        nxt_st.count = st_ff.count + 8'h01;
                    end
                end else if (st_ff.count == VAL_BOTTOM) begin
                    nxt_st.down  = 1'b0;
                    nxt_st.count = st_ff.count + 8'h01;
                end else begin
                    nxt_st.count = st_ff.count - 8'h01;
                end
                ovf_ev = st_ff.down && (st_ff.count == VAL_BOTTOM); // R3
            end else begin
                nxt_st.down  = 1'b0;
                nxt_st.count = at_top ? VAL_BOTTOM : st_ff.count + 8'h01;
                ovf_ev = (wmode == WM_FAST_CMPA) ? at_top : (st_ff.count == VAL_MAX); // R3
            end
            // buffered compare values move over at top in pwm modes
            if (is_pwm(wmode) && at_top) begin // R2
                nxt_st.cmp_a_act = st_ff.cmp_a_buf;
                nxt_st.cmp_b_act = st_ff.cmp_b_buf;
            end
        end
        // waveform outputs
        if (!is_pwm(wmode)) begin
            if (match_a) nxt_st.wave_a = apply_out(st_ff.wave_a, st_ff.ctrl_a[7:6]);
            if (match_b) nxt_st.wave_b = apply_out(st_ff.wave_b, st_ff.ctrl_a[5:4]);
        end else begin
            if (tick && at_top && !is_pc(wmode)) begin
                if (st_ff.ctrl_a[7]) nxt_st.wave_a = !st_ff.ctrl_a[6];
                if (st_ff.ctrl_a[5]) nxt_st.wave_b = !st_ff.ctrl_a[4];
            end
            if (match_a && st_ff.ctrl_a[7]) nxt_st.wave_a = st_ff.ctrl_a[6] ^ st_ff.down;
            if (match_b && st_ff.ctrl_a[5]) nxt_st.wave_b = st_ff.ctrl_a[4] ^ st_ff.down;
        end
        // bus write side effects
        if (bus_wr) begin
            if (avs_address_i == ADDR_CTRL_A) begin
                nxt_st.ctrl_a = {wbyte[7:4], 2'b00, wbyte[1:0]}; // R4
            end else if (avs_address_i == ADDR_CTRL_B) begin
                nxt_st.ctrl_b = wbyte[3:0];
                // force strobes: output only, no flag, no clear, not in pwm
                if (!is_pwm(wmode)) begin // R5 R7 R8
                    if (wbyte[FORCE_A_BIT]) nxt_st.wave_a = apply_out(st_ff.wave_a, st_ff.ctrl_a[7:6]);
                    if (wbyte[FORCE_B_BIT]) nxt_st.wave_b = apply_out(st_ff.wave_b, st_ff.ctrl_a[5:4]);
                end
            end else if (wr_hit) begin
                nxt_st.count       = wbyte; // R13
                nxt_st.block_match = 1'b1; // R14
            end else if (avs_address_i == ADDR_CMP_A) begin
                nxt_st.cmp_a_buf = wbyte;
                if (!is_pwm(wmode)) nxt_st.cmp_a_act = wbyte; // R2
            end else if (avs_address_i == ADDR_CMP_B) begin
                nxt_st.cmp_b_buf = wbyte;
                if (!is_pwm(wmode)) nxt_st.cmp_b_act = wbyte; // R2
            end else if (avs_address_i == ADDR_MASK) begin
                nxt_st.mask = wbyte[2:0]; // R16
            end else if (avs_address_i == ADDR_FLAGS) begin
                nxt_st.flags = st_ff.flags & ~wbyte[2:0]; // R19
            end else if (avs_address_i == ADDR_VECACK) begin
                nxt_st.flags = st_ff.flags & ~wbyte[2:0]; // R18
            end
        end
        // set wins over a clear in the same cycle; forced compares never get here
        if (match_b) nxt_st.flags[BIT_CMP_B] = 1'b1; // R17
        if (match_a) nxt_st.flags[BIT_CMP_A] = 1'b1; // R17
        if (ovf_ev)  nxt_st.flags[BIT_OVF]   = 1'b1; // R3 R17
        // ctc clears only from a real match, never a forced one
        if (match_a && (wmode == WM_CTC) && !wr_hit) nxt_st.count = VAL_BOTTOM; // R8
        nxt_st.irq = global_irq_en_i && |(nxt_st.flags & nxt_st.mask); // R16
        // bus answer one cycle after the request
        if (st_ff.bus_st == BUS_ANSWER) begin
            nxt_st.bus_st = BUS_IDLE;
        end else if (bus_rd || avs_write_i) begin
            nxt_st.bus_st = BUS_ANSWER;
        end
        nxt_st.rdata = BUS_UNMAPPED;
        if (bus_rd) begin
            if (avs_address_i == ADDR_CTRL_A) begin
                nxt_st.rdata[7:0] = st_ff.ctrl_a; // R4
            end else if (avs_address_i == ADDR_CTRL_B) begin
                nxt_st.rdata[7:0] = {4'h0, st_ff.ctrl_b}; // R4 R9
            end else if (avs_address_i == ADDR_COUNT) begin
                nxt_st.rdata[7:0] = st_ff.count; // R13
            end else if (avs_address_i == ADDR_CMP_A) begin
                nxt_st.rdata[7:0] = st_ff.cmp_a_buf;
            end else if (avs_address_i == ADDR_CMP_B) begin
                nxt_st.rdata[7:0] = st_ff.cmp_b_buf;
            end else if (avs_address_i == ADDR_MASK) begin
                nxt_st.rdata[7:0] = {5'h00, st_ff.mask}; // R4
            end else if (avs_address_i == ADDR_FLAGS) begin
                nxt_st.rdata[7:0] = {5'h00, st_ff.flags}; // R4
            end
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_ff <= '{bus_st: BUS_IDLE, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_comb begin
        avs_readdata_o    = st_ff.rdata;
        avs_waitrequest_o = (st_ff.bus_st != BUS_ANSWER);
        wave_out_a_o      = st_ff.wave_a;
        wave_out_b_o      = st_ff.wave_b;
        wave_oe_a_o       = |st_ff.ctrl_a[7:6];
        wave_oe_b_o       = |st_ff.ctrl_a[5:4];
        irq_o             = st_ff.irq;
    end

    // ****************************************
    // assertions
    // ****************************************
    logic [2:0] wm_q;
    assign wm_q = {st_ff.ctrl_b[WAVE_HIGH_BIT], st_ff.ctrl_a[1:0]};

    a_ctrl_b_read: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R9
        $past(bus_rd) && $past(avs_address_i) == ADDR_CTRL_B |-> avs_readdata_o[7:4] == 4'h0)
        else $error("force bits or reserved bits read nonzero");
    a_flag_rsvd: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R4
        $past(bus_rd) && $past(avs_address_i) == ADDR_FLAGS |-> avs_readdata_o[7:3] == 5'h00)
        else $error("flag register reserved bits nonzero");
    a_count_write: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R13
        wr_hit |=> st_ff.count == $past(wbyte))
        else $error("counter write not taken");
    a_block_match: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R14
        wr_hit |=> !match_a && !match_b)
        else $error("match not blocked after counter write");
    a_flag_clear: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R19
        bus_wr && avs_address_i == ADDR_FLAGS && wbyte[BIT_OVF] && !ovf_ev
        |=> !st_ff.flags[BIT_OVF])
        else $error("overflow flag not cleared by write one");
    a_flag_set: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R17
        match_a |=> st_ff.flags[BIT_CMP_A])
        else $error("compare a flag not set on match");
    a_ovf_set: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R3
        tick && wm_q == WM_NORMAL && st_ff.count == VAL_MAX && !wr_hit
        |=> st_ff.flags[BIT_OVF] && st_ff.count == VAL_BOTTOM)
        else $error("overflow at max missed");
    a_irq_gate: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R16
        irq_o |-> $past(global_irq_en_i))
        else $error("interrupt without global enable");
    a_force_pwm: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R5
        is_pwm(wm_q) && !tick |=> $stable(st_ff.wave_a))
        else $error("pwm output moved without tick");
    a_stop_clk: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // R10
        st_ff.ctrl_b[2:0] == CS_STOP && !wr_hit |=> $stable(st_ff.count))
        else $error("stopped timer counted");
    c_ovf: cover property (@(posedge mclk_i) ovf_ev);
    c_match_a: cover property (@(posedge mclk_i) match_a && wm_q == WM_CTC);
    c_pc_turn: cover property (@(posedge mclk_i) tick && is_pc(wm_q) && at_top);
    c_ext: cover property (@(posedge mclk_i) tick && st_ff.ctrl_b[2:0] == CS_EXT_RISE);
endmodule

// [hdl/tmr8_pkg.sv]
// constants for the 8-bit timer/counter block
package tmr8_pkg;
    // register word offsets (byte addresses)
    localparam logic [4:0] ADDR_CTRL_A = 5'h00;
    localparam logic [4:0] ADDR_CTRL_B = 5'h04;
    localparam logic [4:0] ADDR_COUNT  = 5'h08;
    localparam logic [4:0] ADDR_CMP_A  = 5'h0C;
    localparam logic [4:0] ADDR_CMP_B  = 5'h10;
    localparam logic [4:0] ADDR_MASK   = 5'h14;
    localparam logic [4:0] ADDR_FLAGS  = 5'h18;
    localparam logic [4:0] ADDR_VECACK = 5'h1C;
    // field positions
    localparam int OUT_MODE_A_LSB = 6;
    localparam int OUT_MODE_B_LSB = 4;
    localparam int FORCE_A_BIT    = 7;
    localparam int FORCE_B_BIT    = 6;
    localparam int WAVE_HIGH_BIT  = 3;
    localparam int BIT_CMP_B      = 2;
    localparam int BIT_CMP_A      = 1;
    localparam int BIT_OVF        = 0;
    // reset value and counter limits
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] VAL_MAX    = 8'hFF;
    localparam logic [7:0] VAL_BOTTOM = 8'h00;
    // prescaler taps
    localparam int DIV_8    = 8;
    localparam int DIV_64   = 64;
    localparam int DIV_256  = 256;
    localparam int DIV_1024 = 1024;
    // waveform modes
    localparam logic [2:0] WM_NORMAL   = 3'h0;
    localparam logic [2:0] WM_PC_FF    = 3'h1;
    localparam logic [2:0] WM_CTC      = 3'h2;
    localparam logic [2:0] WM_FAST_FF  = 3'h3;
    localparam logic [2:0] WM_PC_CMPA  = 3'h5;
    localparam logic [2:0] WM_FAST_CMPA = 3'h7;
    // clock select codes
    localparam logic [2:0] CS_STOP   = 3'h0;
    localparam logic [2:0] CS_DIV1   = 3'h1;
    localparam logic [2:0] CS_DIV8   = 3'h2;
    localparam logic [2:0] CS_DIV64  = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1K  = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    // compare output codes
    localparam logic [1:0] OM_OFF    = 2'h0;
    localparam logic [1:0] OM_TOGGLE = 2'h1;
    localparam logic [1:0] OM_CLEAR  = 2'h2;
    localparam logic [1:0] OM_SET    = 2'h3;
    localparam logic [31:0] BUS_UNMAPPED = 32'h0000_0000;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ANSWER
    } tmr8_bus_t;

    typedef struct packed {
        tmr8_bus_t   bus_st;
        logic [31:0] rdata;
        logic [7:0]  ctrl_a;
        logic [3:0]  ctrl_b;
        logic [7:0]  count;
        logic [7:0]  cmp_a_buf;
        logic [7:0]  cmp_b_buf;
        logic [7:0]  cmp_a_act;
        logic [7:0]  cmp_b_act;
        logic [2:0]  mask;
        logic [2:0]  flags;
        logic        down;
        logic        block_match;
        logic [9:0]  presc;
        logic        ext_d;
        logic        wave_a;
        logic        wave_b;
        logic        irq;
    } tmr8_state_t;
endpackage
